// ### src/sscp_serial_port.sv
`timescale 1ns/10ps
// Contract
// R1 - Instruction byte first, then data phase
// R2 - Instruction bit 7 set means read
// R3 - Instruction bits 6 and 5 ignored
// R4 - Low five instruction bits select register
// R5 - Data phase spans the register's bytes
// R6 - Input bits captured on serial clock rise
// R7 - Host sends all bytes or aborts
// R8 - Abort ends cycle, next byte is instruction
// R9 - Abort keeps whole bytes, drops partial byte
// R10 - After a cycle, eight rises form instruction
// R11 - Written data waits in buffer until update
// R12 - Profile input change also triggers update
// R13 - Reads return active registers, shift on fall
// R14 - Select high releases both data outputs
// R15 - Select high freezes cycle, resumes later
// R16 - Select tied low needs clean serial clock
// R17 - Control one bit 1 picks pin mode
// R18 - Two-wire mode keeps serial_read_out released
// R19 - Abort leaves register contents untouched
// R20 - Update acts on rise, held over sync period
// R21 - Update pin direction follows internal-update bit
// R22 - Default msb first, control bit 0 selects lsb
// R23 - Highest register bit is its msb
// R24 - Two-wire pin driven only in read phase
module sscp_serial_port (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdio_i,
	output logic sdio_o,
	output logic sdio_oe_n,
	output logic serial_read_out_o,
	output logic serial_read_out_oe_n,
	input wire logic io_reset,
	input wire logic io_update_i,
	output logic io_update_o,
	output logic io_update_oe_n,
	input wire logic [2:0] profile_sel,
	output logic [31:0] ctrl_one,
	output logic [31:0] ctrl_two
);
	import sscp_pkg::*;

	// Two-stage synchronisers; stage one feeds only stage two
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic sclk_d_reg;
	logic upd_d_reg;
	logic [2:0] prof_d_reg;
	logic sclk_s;
	logic cs_act;
	logic din;
	logic abort;
	logic upd_pin;
	logic [2:0] prof_s;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= 8'h02;
			sync2_reg <= 8'h02;
			sclk_d_reg <= 1'b0;
			upd_d_reg <= 1'b0;
			prof_d_reg <= 3'h0;
		end else begin
			sync1_reg <= {profile_sel, io_update_i, io_reset, sdio_i, cs_n, sclk};
			sync2_reg <= sync1_reg;
			sclk_d_reg <= sclk_s;
			upd_d_reg <= upd_pin;
			prof_d_reg <= prof_s;
		end
	end

	assign sclk_s = sync2_reg[0];
	assign cs_act = !sync2_reg[1];
	assign din = sync2_reg[2];
	assign abort = sync2_reg[3];
	assign upd_pin = sync2_reg[4];
	assign prof_s = sync2_reg[7:5];

	// Edges only count while selected, so a deselect freezes the cycle
	logic sclk_rise;
	logic sclk_fall;
	assign sclk_rise = cs_act && sclk_s && !sclk_d_reg; // [R6] [R15]
	assign sclk_fall = cs_act && !sclk_s && sclk_d_reg; // [R13] [R15]

	sscp_state_t state_reg, state_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [1:0] byte_cnt_reg, byte_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [4:0] addr_reg, addr_next;
	logic [31:0] tx_reg, tx_next;
	logic [31:0] buf_one_reg, buf_one_next;
	logic [31:0] buf_two_reg, buf_two_next;
	logic [31:0] act_one_reg, act_one_next;
	logic [31:0] act_two_reg, act_two_next;
	logic dout_reg, dout_next;
	logic sdio_oe_n_reg, sdio_oe_n_next;
	logic sdo_oe_n_reg, sdo_oe_n_next;
	logic upd_o_reg, upd_o_next;
	logic upd_oe_n_reg, upd_oe_n_next;
	logic [2:0] upd_cnt_reg, upd_cnt_next;

	logic lsb_first;
	logic in_only;
	logic int_upd;
	assign lsb_first = act_one_reg[SSCP_LSB_FIRST_BIT]; // [R22]
	assign in_only = act_one_reg[SSCP_SDIO_IN_ONLY_BIT]; // [R17]
	assign int_upd = act_two_reg[SSCP_INT_UPDATE_BIT]; // [R21]

	always_comb begin
		logic [7:0] byte_v;
		logic [1:0] lane;
		logic update;
		logic wr_done;
		byte_v = 8'h00;
		lane = 2'h0;
		update = 1'b0;
		wr_done = 1'b0;
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		byte_cnt_next = byte_cnt_reg;
		shift_next = shift_reg;
		addr_next = addr_reg;
		tx_next = tx_reg;
		buf_one_next = buf_one_reg;
		buf_two_next = buf_two_reg;
		act_one_next = act_one_reg;
		act_two_next = act_two_reg;
		dout_next = dout_reg;
		upd_o_next = upd_o_reg;
		upd_cnt_next = upd_cnt_reg;

		// Serial bit order follows lsb_first for every byte
		byte_v = lsb_first ? {din, shift_reg[7:1]}
			: {shift_reg[6:0], din}; // [R22]
		// First byte on the wire is the register's top byte in msb mode
		lane = lsb_first ? byte_cnt_reg : SSCP_LAST_BYTE - byte_cnt_reg; // [R23]

		if (abort) begin
			// Only the port's own state resets; buffers untouched
			state_next = SSCP_ST_INSTR; // [R8] [R19]
			bit_cnt_next = 3'h0; // [R9]
			byte_cnt_next = 2'h0; // [R8]
		end else if (sclk_rise) begin
			shift_next = byte_v;
			bit_cnt_next = bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == SSCP_LAST_BIT) begin
				case (state_reg)
					SSCP_ST_INSTR: begin
						// Bits 6 and 5 are never looked at
						addr_next = byte_v[SSCP_INSTR_ADDR_LSB +:
							SSCP_INSTR_ADDR_W]; // [R3] [R4]
						byte_cnt_next = 2'h0;
						if (byte_v[SSCP_INSTR_DIR_BIT]) begin // [R2]
							state_next = SSCP_ST_READ; // [R1]
							// Reads see active values, never the buffer
							if (addr_next == SSCP_ADDR_CTRL_ONE)
								tx_next = act_one_reg; // [R13]
							else if (addr_next == SSCP_ADDR_CTRL_TWO)
								tx_next = act_two_reg; // [R13]
							else
								tx_next = 32'h0000_0000;
						end else begin
							state_next = SSCP_ST_WRITE; // [R1]
						end
					end
					SSCP_ST_WRITE: begin
						// Each whole byte lands at once, so abort keeps it
						if (addr_reg == SSCP_ADDR_CTRL_ONE)
							buf_one_next[lane*8 +: 8] = byte_v; // [R9] [R11]
						else if (addr_reg == SSCP_ADDR_CTRL_TWO)
							buf_two_next[lane*8 +: 8] = byte_v; // [R9] [R11]
						byte_cnt_next = byte_cnt_reg + 2'h1;
						if (byte_cnt_reg == SSCP_LAST_BYTE) begin // [R5]
							state_next = SSCP_ST_INSTR; // [R10]
							wr_done = 1'b1;
						end
					end
					SSCP_ST_READ: begin
						byte_cnt_next = byte_cnt_reg + 2'h1;
						if (byte_cnt_reg == SSCP_LAST_BYTE) // [R5]
							state_next = SSCP_ST_INSTR; // [R10]
					end
					default: begin
						state_next = SSCP_ST_INSTR;
					end
				endcase
			end
		end else if (sclk_fall && state_reg == SSCP_ST_READ) begin
			// Next read bit goes out on the falling edge
			dout_next = lsb_first ? tx_reg[0] : tx_reg[31]; // [R13]
			tx_next = lsb_first ? {1'b0, tx_reg[31:1]}
				: {tx_reg[30:0], 1'b0}; // [R13]
		end

		// Internal update: pin becomes an output pulsed after each write
		if (int_upd) begin
			if (wr_done) begin
				upd_cnt_next = 3'(SSCP_UPD_PULSE_CYC);
				upd_o_next = 1'b1;
			end else if (upd_cnt_reg != 3'h0) begin
				upd_cnt_next = upd_cnt_reg - 3'h1;
				upd_o_next = (upd_cnt_reg != 3'h1);
			end
			update = wr_done; // [R21]
		end else begin
			upd_o_next = 1'b0;
			upd_cnt_next = 3'h0;
			update = upd_pin && !upd_d_reg; // [R20]
		end
		if (prof_s != prof_d_reg)
			update = 1'b1; // [R12]
		if (update) begin
			act_one_next = buf_one_next; // [R11]
			act_two_next = buf_two_next; // [R11]
		end

		// Release both pins when deselected or outside a read phase
		sdio_oe_n_next = !(cs_act && state_next == SSCP_ST_READ
			&& !in_only); // [R14] [R18] [R24]
		sdo_oe_n_next = !(cs_act && state_next == SSCP_ST_READ
			&& in_only); // [R14] [R18]
		upd_oe_n_next = !int_upd; // [R21]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= SSCP_ST_INSTR;
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 2'h0;
			shift_reg <= 8'h00;
			addr_reg <= 5'h00;
			tx_reg <= 32'h0000_0000;
			buf_one_reg <= SSCP_CTRL_ONE_RST;
			buf_two_reg <= SSCP_CTRL_TWO_RST;
			act_one_reg <= SSCP_CTRL_ONE_RST;
			act_two_reg <= SSCP_CTRL_TWO_RST;
			dout_reg <= 1'b0;
			sdio_oe_n_reg <= 1'b1;
			sdo_oe_n_reg <= 1'b1;
			upd_o_reg <= 1'b0;
			upd_oe_n_reg <= 1'b1;
			upd_cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			byte_cnt_reg <= byte_cnt_next;
			shift_reg <= shift_next;
			addr_reg <= addr_next;
			tx_reg <= tx_next;
			buf_one_reg <= buf_one_next;
			buf_two_reg <= buf_two_next;
			act_one_reg <= act_one_next;
			act_two_reg <= act_two_next;
			dout_reg <= dout_next;
			sdio_oe_n_reg <= sdio_oe_n_next;
			sdo_oe_n_reg <= sdo_oe_n_next;
			upd_o_reg <= upd_o_next;
			upd_oe_n_reg <= upd_oe_n_next;
			upd_cnt_reg <= upd_cnt_next;
		end
	end

	assign sdio_o = dout_reg;
	assign sdio_oe_n = sdio_oe_n_reg;
	assign serial_read_out_o = dout_reg;
	assign serial_read_out_oe_n = sdo_oe_n_reg;
	assign io_update_o = upd_o_reg;
	assign io_update_oe_n = upd_oe_n_reg;
	assign ctrl_one = act_one_reg;
	assign ctrl_two = act_two_reg;
endmodule

// ### include/sscp_pkg.sv
package sscp_pkg;
	// Register addresses carried in the instruction byte
	localparam logic [4:0] SSCP_ADDR_CTRL_ONE = 5'h00;
	localparam logic [4:0] SSCP_ADDR_CTRL_TWO = 5'h01;
	// Instruction byte fields
	localparam int SSCP_INSTR_DIR_BIT = 7;
	localparam int SSCP_INSTR_ADDR_LSB = 0;
	localparam int SSCP_INSTR_ADDR_W = 5;
	// Index of the last data byte of every register, and of the last bit in a byte
	localparam logic [1:0] SSCP_LAST_BYTE = 2'h3;
	localparam logic [2:0] SSCP_LAST_BIT = 3'h7;
	// Field positions in control_function_one
	localparam int SSCP_LSB_FIRST_BIT = 0;
	localparam int SSCP_SDIO_IN_ONLY_BIT = 1;
	// Field position in control_function_two
	localparam int SSCP_INT_UPDATE_BIT = 23;
	// Reset values
	localparam logic [31:0] SSCP_CTRL_ONE_RST = 32'h0000_0000;
	localparam logic [31:0] SSCP_CTRL_TWO_RST = 32'h0040_0820;
	// Internally generated update pulse width
	localparam int SSCP_CLK_PERIOD_NS = 10;
	localparam int SSCP_UPD_PULSE_NS = 40;
	localparam int SSCP_UPD_PULSE_CYC =
		(SSCP_UPD_PULSE_NS + SSCP_CLK_PERIOD_NS - 1) / SSCP_CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SSCP_ST_INSTR = 2'b00,
		SSCP_ST_WRITE = 2'b01,
		SSCP_ST_READ = 2'b10
	} sscp_state_t;
endpackage

// ### test/sscp_host_model.sv
`timescale 1ns/10ps
module sscp_host_model (
	output logic sclk,
	output logic cs_n,
	output wire logic sdio_i,
	output logic io_reset,
	input wire logic sdio_o,
	input wire logic sdio_oe_n,
	input wire logic sro
);
	logic drv = 1'b0, lsb = 1'b0, three = 1'b0, frz = 1'b0;
	// Device wins the shared pin while it drives
	assign sdio_i = sdio_oe_n ? drv : sdio_o;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		io_reset = 1'b0;
	end
	task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
		input int n, output logic [31:0] rd);
		int k;
		rd = '0;
		cs_n = 1'b0;
		#100;
		for (int i = 0; i < 8 + n; i++) begin
			k = lsb ? (i < 8 ? i : i - 8) : (i < 8 ? 7 - i : 39 - i);
			if (i < 8) drv = ins[k];
			else if (ins[7]) drv = ~drv;
			else drv = wd[k];
			#62 sclk = 1'b1;
			if (i >= 8) rd[k] = three ? sro : sdio_i;
			#63 sclk = 1'b0;
			if (frz && i == 24) begin
				// Stray edges while deselected must be ignored
				#60 cs_n = 1'b1;
				#100;
				repeat (4) begin
					#62 sclk = 1'b1;
					#63 sclk = 1'b0;
				end
				#100 cs_n = 1'b0;
				#100;
			end
		end
		#100 cs_n = 1'b1;
		drv = ~drv;
		frz = 1'b0;
		// Keep select high a while so back-to-back calls never glitch it
		#100;
	endtask
	task automatic abort();
		io_reset = 1'b1;
		#100 io_reset = 1'b0;
		#100;
	endtask
endmodule

// ### test/sscp_serial_port_sva.sv
`timescale 1ns/10ps
module sscp_serial_port_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic io_reset,
	input wire logic io_update_i,
	input wire logic [2:0] profile_sel,
	input wire logic sdio_oe_n,
	input wire logic serial_read_out_oe_n,
	input wire logic io_update_o,
	input wire logic io_update_oe_n,
	input wire logic [31:0] ctrl_one,
	input wire logic [31:0] ctrl_two
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Cycles since io_update_i was last high or profile_sel last changed, saturating
	logic [3:0] quiet_reg, quiet_next;
	logic [2:0] prof_reg;
	always_comb begin
		quiet_next = quiet_reg + ((quiet_reg == 4'hf) ? 4'h0 : 4'h1);
		if (io_update_i || profile_sel != prof_reg)
			quiet_next = 4'h0;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet_reg <= 4'h0;
			prof_reg <= 3'h0;
		end else begin
			quiet_reg <= quiet_next;
			prof_reg <= profile_sel;
		end
	end
	sequence s_upd_pulse;
		io_update_o [*4] ##1 !io_update_o;
	endsequence
	a_buffer_held: assert property (quiet_reg >= 4'h6 && io_update_oe_n &&
		!ctrl_two[23] |=> $stable(ctrl_one) && $stable(ctrl_two))
		else $error("active register changed without update");
	a_abort_keeps: assert property (io_reset && quiet_reg >= 4'h6
		|=> $stable(ctrl_one) && $stable(ctrl_two))
		else $error("abort changed a register");
	a_abort_idle: assert property (io_reset [*5]
		|-> sdio_oe_n && serial_read_out_oe_n)
		else $error("pin driven during abort");
	a_cs_release: assert property (cs_n [*5]
		|-> sdio_oe_n && serial_read_out_oe_n)
		else $error("pin driven while deselected");
	a_two_wire: assert property (!ctrl_one[1] && !$past(ctrl_one[1])
		|-> serial_read_out_oe_n)
		else $error("separate output driven in two-wire mode");
	a_input_only: assert property (ctrl_one[1] && $past(ctrl_one[1])
		|-> sdio_oe_n)
		else $error("data pin driven in input-only mode");
	a_upd_pulse: assert property ($rose(io_update_o) |-> s_upd_pulse)
		else $error("internal update pulse width wrong");
	a_upd_dir: assert property (!io_update_oe_n
		|-> ctrl_two[23] || $past(ctrl_two[23]))
		else $error("update pin driven in external mode");
endmodule
bind sscp_serial_port sscp_serial_port_sva u_sva (.ref_clk(ref_clk),
	.rst_n(rst_n), .cs_n(cs_n), .io_reset(io_reset),
	.io_update_i(io_update_i), .profile_sel(profile_sel),
	.sdio_oe_n(sdio_oe_n), .serial_read_out_oe_n(serial_read_out_oe_n),
	.io_update_o(io_update_o), .io_update_oe_n(io_update_oe_n),
	.ctrl_one(ctrl_one), .ctrl_two(ctrl_two));

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench;
	import sscp_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, io_update_i = 1'b0;
	logic [2:0] profile_sel = 3'h0;
	logic [31:0] rd;
	wire sclk, cs_n, sdio_i, io_reset, sdio_o, sdio_oe_n, sro, upd_oe_n;
	wire [31:0] ctrl_one, ctrl_two;
	int n_errors = 0, total_checks = 0, cyc = 0;
	initial forever #5 ref_clk = ~ref_clk;
	sscp_serial_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
		.cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
		.serial_read_out_o(sro), .serial_read_out_oe_n(),
		.io_reset(io_reset), .io_update_i(io_update_i), .io_update_o(),
		.io_update_oe_n(upd_oe_n), .profile_sel(profile_sel),
		.ctrl_one(ctrl_one),
		.ctrl_two(ctrl_two));
	sscp_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
		.io_reset(io_reset), .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .sro(sro));
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic upd();
		@(posedge ref_clk) #1 io_update_i = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1 io_update_i = 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
	// Timeout well beyond the roughly 4200 cycles the tests need
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		repeat (5) @(posedge ref_clk);
		chk(ctrl_one, SSCP_CTRL_ONE_RST);
		chk(ctrl_two, SSCP_CTRL_TWO_RST);
		u_host.xfer(8'h61, 32'h1234_5678, 32, rd);
		chk(ctrl_two, SSCP_CTRL_TWO_RST);
		u_host.xfer(8'h81, 32'h0, 32, rd);
		chk(rd, SSCP_CTRL_TWO_RST);
		upd();
		chk(ctrl_two, 32'h1234_5678);
		u_host.xfer(8'he1, 32'h0, 32, rd);
		chk(rd, 32'h1234_5678);
		$display("test write_read done");
		u_host.xfer(8'h00, 32'ha5c3_0000, 11, rd);
		u_host.abort();
		@(posedge ref_clk) #1 profile_sel = 3'h5;
		repeat (8) @(posedge ref_clk);
		chk(ctrl_one, 32'ha500_0000);
		chk(ctrl_two, 32'h1234_5678);
		$display("test abort done");
		u_host.xfer(8'h00, 32'h0000_0003, 32, rd);
		upd();
		chk(ctrl_one, 32'h0000_0003);
		u_host.lsb = 1'b1;
		u_host.three = 1'b1;
		u_host.frz = 1'b1;
		u_host.xfer(8'h81, 32'h0, 32, rd);
		chk(rd, 32'h1234_5678);
		$display("test lsb_three_wire done");
		chk({31'h0, upd_oe_n}, 32'h0000_0001);
		u_host.xfer(8'h01, 32'h0080_0000, 32, rd);
		upd();
		chk(ctrl_two, 32'h0080_0000);
		chk({31'h0, upd_oe_n}, 32'h0000_0000);
		u_host.xfer(8'h00, 32'h0000_0103, 32, rd);
		repeat (8) @(posedge ref_clk);
		chk(ctrl_one, 32'h0000_0103);
		$display("test internal_update done");
		close_out();
	end
endmodule
